// file: core/ueb_top.sv
// Purpose: one endpoint's bank handshake between USB packet engine and firmware
// Assumes: packet engine gives one-cycle token/byte strobes; firmware selects endpoint outside
// Notes: two banks at most; answer given the cycle after the token
`include "ueb_map.svh"
module ueb_top #(
  parameter int BANK_AW = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tok_setup,
  input wire logic tok_out,
  input wire logic tok_in,
  input wire logic pkt_byte_valid,
  input wire logic [7:0] pkt_byte,
  input wire logic pkt_end,
  input wire logic pkt_crc_err,
  input wire logic pkt_retry,
  input wire logic in_byte_ready,
  output ueb_pkg::ueb_hs_t hs_code,
  output logic hs_valid,
  output logic [7:0] in_byte,
  output logic endpoint_irq
);
  import ueb_pkg::*;

  localparam int BSZ = 1 << BANK_AW;
  ueb_type_t ep_type_reg;
  logic dbl_reg, stall_request_reg;
  logic [`UEB_FLAG_W-1:0] flags_reg, ien_reg;
  logic [1:0] full_reg; // per bank holds a packet
  logic [BANK_AW:0] cnt_reg [0:1];
  logic cpu_bank_reg, usb_bank_reg, last_wr_reg;
  logic [BANK_AW:0] cpu_ptr_reg, usb_ptr_reg;
  ueb_cstate_t cst_reg;
  logic status_nak_reg;
  logic [7:0] mem_rd;
  logic setup_seen_reg, tok_in_d_reg;

  logic is_ctrl, is_in, wr_acc, rd_acc, any_tok, rx_pkt, rx_data_ok;
  logic stall_clr, kill, eprst, bank_clr, rw_allowed;
  logic [`UEB_FLAG_W-1:0] fl_clr;
  assign is_ctrl = (ep_type_reg == UEB_CONTROL);
  assign is_in = (ep_type_reg == UEB_BULK_IN);
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign any_tok = tok_setup || tok_out || tok_in;
  assign stall_clr = wr_acc && paddr == `UEB_OFF_CMD && pwdata[`UEB_C_STALLCLR];
  assign kill = wr_acc && paddr == `UEB_OFF_CMD && pwdata[`UEB_C_KILL];
  assign eprst = wr_acc && paddr == `UEB_OFF_CMD && pwdata[`UEB_C_EPRST];
  // flags are cleared by writing zero to the bit while it reads one
  assign fl_clr = (wr_acc && paddr == `UEB_OFF_FLAGS) ? ~pwdata[`UEB_FLAG_W-1:0] : '0;
  assign bank_clr = wr_acc && paddr == `UEB_OFF_FLAGS && !pwdata[`UEB_F_BANK] && !is_ctrl;
  // data accepted when not stalled, or in a setup token cycle
  assign rx_data_ok = !stall_request_reg || tok_setup;
  assign rx_pkt = pkt_end && rx_data_ok;

  always_comb begin
    if (is_in) begin
      rw_allowed = !full_reg[cpu_bank_reg] && cpu_ptr_reg < BSZ[BANK_AW:0];
    end else begin
      rw_allowed = full_reg[cpu_bank_reg] && cpu_ptr_reg < cnt_reg[cpu_bank_reg];
    end
  end

  // configuration and stall request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep_type_reg <= UEB_CONTROL;
      dbl_reg <= 1'b0;
      ien_reg <= '0;
      stall_request_reg <= 1'b0;
    end else begin
      if (wr_acc && paddr == `UEB_OFF_CTRL) begin
        ep_type_reg <= ueb_type_t'(pwdata[`UEB_CTRL_TYPE]);
        dbl_reg <= pwdata[`UEB_CTRL_DBL];
        if (pwdata[`UEB_CTRL_STALL]) begin
          stall_request_reg <= 1'b1;
        end
      end
      if (wr_acc && paddr == `UEB_OFF_IEN) begin
        ien_reg <= pwdata[`UEB_FLAG_W-1:0];
      end
      // setup clears stall on control
      // endpoint reset leaves the request alone, only the clear bit or a control setup ends it
      if (stall_clr || (tok_setup && is_ctrl)) begin
        stall_request_reg <= 1'b0;
      end
    end
  end

  // handshake answer, one cycle after token
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_valid <= 1'b0;
      hs_code <= UEB_HS_NONE;
    end else begin
      hs_valid <= any_tok;
      if (tok_setup && is_ctrl) begin
        hs_code <= UEB_HS_ACK; // setup always acked
      end else if (pkt_retry) begin
        hs_code <= UEB_HS_NAK;
      end else if (stall_request_reg && any_tok) begin
        hs_code <= UEB_HS_STALL;
      end else if (tok_in && is_ctrl && cst_reg == UEB_CS_DATA && !status_nak_reg && !flags_reg[`UEB_F_IN]) begin
        hs_code <= UEB_HS_DATA;
      end else if (tok_out && is_ctrl && cst_reg == UEB_CS_DATA) begin
        hs_code <= status_nak_reg ? UEB_HS_ACK : UEB_HS_NAK;
      end else if (tok_in) begin
        hs_code <= full_reg[usb_bank_reg] ? UEB_HS_DATA : UEB_HS_NAK;
      end else if (tok_out) begin
        hs_code <= full_reg[usb_bank_reg] && !is_ctrl ? UEB_HS_NAK : UEB_HS_ACK;
      end else begin
        hs_code <= UEB_HS_NONE;
      end
    end
  end

  // control transfer stage tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cst_reg <= UEB_CS_IDLE;
      status_nak_reg <= 1'b0;
    end else if (eprst || (tok_setup && is_ctrl)) begin
      cst_reg <= UEB_CS_DATA; // setup takes priority
      status_nak_reg <= 1'b0;
    end else if (is_ctrl && tok_out && cst_reg == UEB_CS_DATA && !stall_request_reg) begin
      status_nak_reg <= 1'b1;
      if (status_nak_reg) begin
        cst_reg <= UEB_CS_STATUS; // await next setup
      end
    end
  end

  // endpoint flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= '0;
    end else if (eprst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_reg & ~fl_clr;
      if (is_ctrl && status_nak_reg) begin
        flags_reg[`UEB_F_IN] <= 1'b1;
      end
      if (is_ctrl) begin
        if (!full_reg[0] && cst_reg == UEB_CS_DATA && !fl_clr[`UEB_F_IN]) begin
          flags_reg[`UEB_F_IN] <= flags_reg[`UEB_F_IN] | (hs_valid && hs_code == UEB_HS_DATA);
        end
        if (rx_pkt && !setup_seen_reg) begin
          flags_reg[`UEB_F_OUT] <= 1'b1; // retry out sets flags
          if (status_nak_reg) begin
            flags_reg[`UEB_F_IN] <= 1'b1;
          end
        end
        if (pkt_end && setup_seen_reg) begin
          flags_reg <= '0;
          flags_reg[`UEB_F_SETUP] <= 1'b1;
        end
      end else begin
        // in bank free or out bank full
        // raised once per bank: the bank flag stays up until firmware releases
        // the bank, so a flag cleared by firmware is not raised again meanwhile
        if (!flags_reg[`UEB_F_BANK] && !bank_clr &&
            (is_in ? !full_reg[cpu_bank_reg] : full_reg[cpu_bank_reg])) begin
          flags_reg[is_in ? `UEB_F_IN : `UEB_F_OUT] <= 1'b1;
          flags_reg[`UEB_F_BANK] <= 1'b1;
        end
        if (bank_clr) begin
          flags_reg[`UEB_F_BANK] <= 1'b0; // reload from new bank
        end
      end
      if (hs_valid && hs_code == UEB_HS_STALL) begin
        flags_reg[`UEB_F_STALLED] <= 1'b1;
      end
      if (ep_type_reg == UEB_ISO && pkt_end && pkt_crc_err) begin
        flags_reg[`UEB_F_STALLED] <= 1'b1;
        flags_reg[`UEB_F_OUT] <= 1'b1;
      end
      if (ep_type_reg == UEB_ISO && tok_in && !full_reg[usb_bank_reg]) begin
        flags_reg[`UEB_F_UNDER] <= 1'b1;
      end
      if (pkt_byte_valid && rx_data_ok && usb_ptr_reg == BSZ[BANK_AW:0]) begin
        flags_reg[`UEB_F_OVER] <= 1'b1;
      end
      if (hs_valid && hs_code == UEB_HS_NAK && tok_in_d_reg) begin
        flags_reg[`UEB_F_NAKIN] <= 1'b1;
      end
    end
  end

  // helpers: setup latch and in-token delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_seen_reg <= 1'b0;
      tok_in_d_reg <= 1'b0;
    end else begin
      tok_in_d_reg <= tok_in;
      if (tok_setup && is_ctrl) begin
        setup_seen_reg <= 1'b1;
      end else if (tok_out || tok_in || pkt_end) begin
        setup_seen_reg <= 1'b0;
      end
    end
  end

  // bank bookkeeping for host side and cpu side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_reg <= '0;
      cnt_reg[0] <= '0;
      cnt_reg[1] <= '0;
      cpu_bank_reg <= 1'b0;
      usb_bank_reg <= 1'b0;
      last_wr_reg <= 1'b0;
      cpu_ptr_reg <= '0;
      usb_ptr_reg <= '0;
    end else if (eprst || (tok_setup && is_ctrl)) begin
      full_reg <= '0;
      cpu_bank_reg <= 1'b0;
      usb_bank_reg <= 1'b0;
      cpu_ptr_reg <= '0;
      usb_ptr_reg <= '0;
      cnt_reg[0] <= '0;
      cnt_reg[1] <= '0;
    end else begin
      // host writes OUT bytes, leading bytes only
      if (pkt_byte_valid && rx_data_ok && !is_in && usb_ptr_reg < BSZ[BANK_AW:0]) begin
        usb_ptr_reg <= usb_ptr_reg + 1'b1;
      end
      // a corrupted packet is not kept, but the next one starts at byte zero
      if (rx_pkt && !is_in) begin
        usb_ptr_reg <= '0;
      end
      if (rx_pkt && !is_in && !pkt_crc_err) begin
        cnt_reg[usb_bank_reg] <= usb_ptr_reg;
        full_reg[usb_bank_reg] <= 1'b1;
        if (dbl_reg && !is_ctrl) begin
          usb_bank_reg <= !usb_bank_reg;
        end
      end
      // host reads IN bytes
      if (is_in && in_byte_ready && full_reg[usb_bank_reg]) begin
        if (usb_ptr_reg + 1'b1 >= cnt_reg[usb_bank_reg]) begin
          full_reg[usb_bank_reg] <= 1'b0;
          usb_ptr_reg <= '0;
          usb_bank_reg <= dbl_reg ? !usb_bank_reg : 1'b0;
        end else begin
          usb_ptr_reg <= usb_ptr_reg + 1'b1;
        end
      end
      // cpu data port
      if ((wr_acc || rd_acc) && paddr == `UEB_OFF_DATA && rw_allowed) begin
        cpu_ptr_reg <= cpu_ptr_reg + 1'b1;
      end
      // firmware orders flag clears before this
      if (bank_clr) begin
        full_reg[cpu_bank_reg] <= is_in;
        if (is_in) begin
          cnt_reg[cpu_bank_reg] <= cpu_ptr_reg;
          last_wr_reg <= cpu_bank_reg;
        end
        cpu_ptr_reg <= '0;
        cpu_bank_reg <= dbl_reg ? !cpu_bank_reg : 1'b0;
      end
      if (kill && is_in) begin
        full_reg[last_wr_reg] <= 1'b0;
      end
      // control out data freed by clearing out or setup flag
      if (is_ctrl && (fl_clr[`UEB_F_OUT] || fl_clr[`UEB_F_SETUP]) && (flags_reg[`UEB_F_OUT]
          || flags_reg[`UEB_F_SETUP])) begin
        full_reg[0] <= 1'b0;
        cnt_reg[0] <= '0; // the emptied control bank counts no bytes
      end
    end
  end

  logic [BANK_AW-1:0] mem_addr;
  // cpu reads of OUT data follow the cpu pointer, never the host one
  assign mem_addr = cpu_ptr_reg[BANK_AW-1:0];
  // single bank array; cpu writes IN, host writes OUT
  ueb_mem #(.AW(BANK_AW + 1), .DW(8)) ueb_mem_inst (
    .pclk(pclk),
    .we((pkt_byte_valid && rx_data_ok && usb_ptr_reg < BSZ[BANK_AW:0]) ||
        (wr_acc && paddr == `UEB_OFF_DATA && rw_allowed)),
    .waddr(pkt_byte_valid ? {usb_bank_reg, usb_ptr_reg[BANK_AW-1:0]} : {cpu_bank_reg, cpu_ptr_reg[BANK_AW-1:0]}),
    .wdata(pkt_byte_valid ? pkt_byte : pwdata[7:0]),
    .raddr(is_in ? {usb_bank_reg, usb_ptr_reg[BANK_AW-1:0]} : {cpu_bank_reg, mem_addr}),
    .rdata(mem_rd)
  );

  // apb read mux and fixed zero-wait answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      in_byte <= '0;
      endpoint_irq <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr > `UEB_OFF_CMD;
      in_byte <= mem_rd;
      endpoint_irq <= |(flags_reg & ien_reg);
      prdata <= '0;
      case (paddr)
        `UEB_OFF_CTRL: prdata <= {28'h0, stall_request_reg, dbl_reg, ep_type_reg};
        `UEB_OFF_FLAGS: prdata <= {23'h0, rw_allowed && !is_ctrl && !stall_request_reg,
                                   flags_reg[`UEB_F_BANK] && !is_ctrl, flags_reg[`UEB_F_W_LOW]};
        `UEB_OFF_IEN: prdata <= {24'h0, ien_reg};
        `UEB_OFF_DATA: prdata <= {24'h0, mem_rd};
        `UEB_OFF_COUNT: prdata <= {{(31-BANK_AW){1'b0}}, cnt_reg[cpu_bank_reg]};
        default: prdata <= '0; // command bits always read zero
      endcase
    end
  end

  a_stall_held: assert property (@(posedge pclk) disable iff (!presetn)
    stall_request_reg && !stall_clr && !(tok_setup && is_ctrl) |=> stall_request_reg)
    else $error("stall request dropped");
  a_stall_flag: assert property (@(posedge pclk) disable iff (!presetn)
    hs_valid && hs_code == UEB_HS_STALL && !eprst |=> flags_reg[`UEB_F_STALLED])
    else $error("stall sent not flagged");
  a_setup_ack: assert property (@(posedge pclk) disable iff (!presetn)
    tok_setup && is_ctrl |=> hs_valid && hs_code == UEB_HS_ACK && !stall_request_reg)
    else $error("setup not acked");
  a_retry_first: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_retry && any_tok && !(tok_setup && is_ctrl) |=> hs_code == UEB_HS_NAK)
    else $error("stall beat retry");
  a_ctrl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == `UEB_OFF_FLAGS && is_ctrl |=> prdata[8:7] == 2'h0)
    else $error("control bank bits visible");
  a_zlp_count: assert property (@(posedge pclk) disable iff (!presetn)
    rx_pkt && !is_in && !pkt_crc_err && usb_ptr_reg == '0 && !pkt_byte_valid && !eprst && !tok_setup
    |=> cnt_reg[$past(usb_bank_reg)] == '0)
    else $error("zero length count wrong");
  a_irq_map: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 endpoint_irq == $past(|(flags_reg & ien_reg)))
    else $error("interrupt mismatch");
  a_over_flag: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_byte_valid && rx_data_ok && usb_ptr_reg == BSZ[BANK_AW:0] && !eprst |=> flags_reg[`UEB_F_OVER])
    else $error("overflow not flagged");
  c_stall: cover property (@(posedge pclk) hs_valid && hs_code == UEB_HS_STALL);
  c_setup: cover property (@(posedge pclk) flags_reg[`UEB_F_SETUP]);
  c_dbl: cover property (@(posedge pclk) dbl_reg && full_reg == 2'h3);
endmodule

// file: core/ueb_map.svh
// Purpose: register offsets and field positions for the endpoint bank handshake block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: register figures used only by ueb_top live here, the bench uses literal offsets; type and handshake codes live in ueb_pkg
`ifndef UEB_MAP_SVH
`define UEB_MAP_SVH
`define UEB_OFF_CTRL 12'h000
`define UEB_OFF_FLAGS 12'h004
`define UEB_OFF_IEN 12'h008
`define UEB_OFF_DATA 12'h00c
`define UEB_OFF_COUNT 12'h010
`define UEB_OFF_CMD 12'h014
// ctrl register fields
`define UEB_CTRL_TYPE 1:0
`define UEB_CTRL_DBL 2
`define UEB_CTRL_STALL 3
// flag register bits
`define UEB_F_OUT 0
`define UEB_F_IN 1
`define UEB_F_SETUP 2
`define UEB_F_STALLED 3
`define UEB_F_NAKIN 4
`define UEB_F_UNDER 5
`define UEB_F_OVER 6
`define UEB_F_BANK 7
`define UEB_F_RW_ALLOWED 8
`define UEB_FLAG_W 8
`define UEB_F_W_LOW 6:0
// command register bits (write one to act)
`define UEB_C_STALLCLR 0
`define UEB_C_KILL 1
`define UEB_C_EPRST 2
`endif

// file: core/ueb_pkg.sv
package ueb_pkg;
  typedef enum logic [1:0] {UEB_CONTROL = 2'h0, UEB_ISO = 2'h1, UEB_BULK_OUT = 2'h2, UEB_BULK_IN = 2'h3} ueb_type_t;
  typedef enum logic [2:0] {UEB_HS_NONE = 3'h0, UEB_HS_ACK = 3'h1, UEB_HS_NAK = 3'h3, UEB_HS_STALL = 3'h2,
                            UEB_HS_DATA = 3'h6} ueb_hs_t;
  typedef enum logic [1:0] {UEB_CS_IDLE = 2'h0, UEB_CS_DATA = 2'h1, UEB_CS_STATUS = 2'h3} ueb_cstate_t;
endpackage

// file: core/ueb_mem.sv
// Purpose: bank storage for the endpoint, registered read data
// Assumes: one write and one read port on pclk
// Notes: no reset on the array, contents are don't-care until written
module ueb_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem_reg [0:(1<<AW)-1];

  // synchronous write and registered read
  always_ff @(posedge pclk) begin
    if (we) begin
      mem_reg[waddr] <= wdata;
    end
    rdata <= mem_reg[raddr];
  end
endmodule

// file: bench/ueb_host_model.sv
// Purpose: packet engine stand-in playing the USB host side of one endpoint
// Assumes: token, byte and end strobes last one pclk cycle each
// Notes: each end strobe inverts the byte lines, which then hold; after a zero-length packet that restores the last byte
module ueb_host_model (
  input wire logic pclk,
  input wire logic hs_valid,
  input wire ueb_pkg::ueb_hs_t hs_code,
  output logic tok_setup,
  output logic tok_out,
  output logic tok_in,
  output logic pkt_byte_valid,
  output logic [7:0] pkt_byte,
  output logic pkt_end,
  output logic pkt_crc_err,
  output logic pkt_retry,
  output logic in_byte_ready
);
  import ueb_pkg::*;
  // all strobes quiet at time zero
  initial begin
    {tok_setup, tok_out, tok_in, pkt_byte_valid, pkt_end, pkt_crc_err, pkt_retry, in_byte_ready} = 8'h00;
    pkt_byte = 8'h5a;
  end
  // kind 0 setup, 1 out, 2 in; handshake waited for a few edges only
  task automatic token(input int kind, input logic retry, output ueb_hs_t hs);
    int i;
    @(posedge pclk);
    tok_setup <= (kind == 0);
    tok_out <= (kind == 1);
    tok_in <= (kind == 2);
    pkt_retry <= retry;
    hs = UEB_HS_NONE;
    for (i = 0; i < 4 && hs == UEB_HS_NONE; i++) begin
      @(posedge pclk);
      {tok_setup, tok_out, tok_in} <= 3'h0;
      if (hs_valid === 1'b1) hs = hs_code;
    end
    pkt_retry <= 1'b0;
    // consume one byte of a data answer, as the engine would
    if (hs == UEB_HS_DATA) begin
      @(posedge pclk);
      in_byte_ready <= 1'b1;
      @(posedge pclk);
      in_byte_ready <= 1'b0;
    end
  endtask
  // bytes 8'h10 upward, then the end strobe with the crc flag beside it
  task automatic packet(input int n, input logic crc);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge pclk);
      pkt_byte_valid <= 1'b1;
      pkt_byte <= 8'h10 + 8'(i);
    end
    @(posedge pclk);
    pkt_byte_valid <= 1'b0;
    pkt_byte <= ~pkt_byte;
    pkt_end <= 1'b1;
    pkt_crc_err <= crc;
    @(posedge pclk);
    pkt_end <= 1'b0;
    pkt_crc_err <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
endmodule

// file: bench/tb_ueb_top.sv
// Purpose: self-checking bench for the endpoint bank handshake block
// Assumes: flag enables sit at the same bit positions as the flags
// Notes: flags cleared by writing zero, so clear masks carry ones elsewhere
module tb_ueb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ueb_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic last_err;
  int mismatches = 0;
  int tests_run = 0;
  wire [31:0] prdata;
  wire pready, pslverr, hs_valid, endpoint_irq;
  wire tok_setup, tok_out, tok_in, pkt_byte_valid, pkt_end, pkt_crc_err, pkt_retry, in_byte_ready;
  wire [7:0] pkt_byte, in_byte;
  ueb_hs_t hs_code;
  ueb_hs_t hs;
  ueb_top #(.BANK_AW(6)) ueb_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tok_setup(tok_setup), .tok_out(tok_out), .tok_in(tok_in), .pkt_byte_valid(pkt_byte_valid),
    .pkt_byte(pkt_byte), .pkt_end(pkt_end), .pkt_crc_err(pkt_crc_err), .pkt_retry(pkt_retry),
    .in_byte_ready(in_byte_ready), .hs_code(hs_code), .hs_valid(hs_valid), .in_byte(in_byte),
    .endpoint_irq(endpoint_irq));
  ueb_host_model ueb_host_model_inst (.pclk(pclk), .hs_valid(hs_valid), .hs_code(hs_code),
    .tok_setup(tok_setup), .tok_out(tok_out), .tok_in(tok_in), .pkt_byte_valid(pkt_byte_valid),
    .pkt_byte(pkt_byte), .pkt_end(pkt_end), .pkt_crc_err(pkt_crc_err), .pkt_retry(pkt_retry),
    .in_byte_ready(in_byte_ready));
  // 50 MHz
  always #10 pclk = ~pclk;
  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_hs(input ueb_hs_t got, input ueb_hs_t exp);
    chk({29'h0, got}, {29'h0, exp});
  endtask
  // one apb transfer; only the watchdog ends a wait for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  // type and stall set, then the endpoint reset so every scenario starts clean
  // one endpoint only; its selection happens outside this block
  task automatic setup_ep(input logic [31:0] ctrl);
    wr(12'h000, ctrl);
    wr(12'h014, 32'h4);
  endtask
  task automatic t_stall();
    setup_ep(32'ha);
    wr(12'h008, 32'h8);
    ueb_host_model_inst.token(1, 1'b0, hs);
    chk_hs(hs, UEB_HS_STALL);
    ueb_host_model_inst.packet(4, 1'b0);
    ueb_host_model_inst.token(1, 1'b0, hs);
    chk_hs(hs, UEB_HS_STALL);
    rd_chk(12'h004, 32'h109, 32'h8);
    chk({31'h0, endpoint_irq}, 32'h1);
    ueb_host_model_inst.token(1, 1'b1, hs);
    chk({31'h0, hs == UEB_HS_STALL}, 32'h0);
    wr(12'h014, 32'h1);
    rd_chk(12'h000, 32'h8, 32'h0);
    rd_chk(12'h014, 32'h7, 32'h0);
    wr(12'h004, 32'h1f7);
    // flag clears at the access edge, the registered interrupt one edge later
    repeat (2) @(posedge pclk);
    chk({31'h0, endpoint_irq}, 32'h0);
    ueb_host_model_inst.token(1, 1'b0, hs);
    chk_hs(hs, UEB_HS_ACK);
    rd_chk(12'h018, 32'hffffffff, 32'h0);
    chk({31'h0, last_err}, 32'h1);
  endtask
  // setup on a stalled control endpoint
  task automatic t_setup();
    setup_ep(32'h8);
    ueb_host_model_inst.token(0, 1'b0, hs);
    chk_hs(hs, UEB_HS_ACK);
    ueb_host_model_inst.packet(8, 1'b0);
    rd_chk(12'h004, 32'h18f, 32'h4);
    rd_chk(12'h000, 32'h8, 32'h0);
    wr(12'h004, 32'h1fb);
    rd_chk(12'h010, 32'hff, 32'h0);
    // status of a control read: first OUT token refused, the retry taken
    ueb_host_model_inst.token(1, 1'b0, hs);
    chk_hs(hs, UEB_HS_NAK);
    ueb_host_model_inst.token(1, 1'b0, hs);
    chk_hs(hs, UEB_HS_ACK);
    ueb_host_model_inst.packet(0, 1'b0);
    rd_chk(12'h004, 32'h7, 32'h3);
    wr(12'h004, 32'h1fd);
    rd_chk(12'h004, 32'h2, 32'h2);
  endtask
  // double-bank out: second packet lands while the first is unread
  task automatic t_out();
    int i;
    setup_ep(32'h6);
    wr(12'h008, 32'h1);
    ueb_host_model_inst.token(1, 1'b0, hs);
    chk_hs(hs, UEB_HS_ACK);
    ueb_host_model_inst.packet(3, 1'b0);
    ueb_host_model_inst.token(1, 1'b0, hs);
    ueb_host_model_inst.packet(5, 1'b0);
    rd_chk(12'h004, 32'h181, 32'h181);
    chk({31'h0, endpoint_irq}, 32'h1);
    rd_chk(12'h010, 32'hff, 32'h3);
    for (i = 0; i < 3; i++) rd_chk(12'h00c, 32'hff, 32'h10 + i);
    rd_chk(12'h004, 32'h100, 32'h0);
    wr(12'h004, 32'h1fe);
    repeat (2) @(posedge pclk);
    chk({31'h0, endpoint_irq}, 32'h0);
    wr(12'h004, 32'h17f);
    rd_chk(12'h004, 32'h181, 32'h181);
    rd_chk(12'h010, 32'hff, 32'h5);
    // out flag cleared before bank control
    wr(12'h004, 32'h1fe);
    wr(12'h004, 32'h17f);
    ueb_host_model_inst.token(1, 1'b0, hs);
    ueb_host_model_inst.packet(0, 1'b0);
    rd_chk(12'h010, 32'hff, 32'h0);
  endtask
  // bulk in: send one bank, then kill the next before the host asks
  task automatic t_in();
    setup_ep(32'h3);
    rd_chk(12'h004, 32'h182, 32'h182);
    wr(12'h00c, 32'ha5);
    wr(12'h004, 32'h1fd);
    wr(12'h004, 32'h17f);
    ueb_host_model_inst.token(2, 1'b0, hs);
    chk_hs(hs, UEB_HS_DATA);
    chk({24'h0, in_byte}, 32'ha5);
    wr(12'h00c, 32'h3c);
    wr(12'h004, 32'h1fd);
    wr(12'h004, 32'h17f);
    wr(12'h014, 32'h2);
    ueb_host_model_inst.token(2, 1'b0, hs);
    chk_hs(hs, UEB_HS_NAK);
  endtask
  // isochronous crc error and empty-bank read
  task automatic t_iso();
    setup_ep(32'h1);
    ueb_host_model_inst.token(1, 1'b0, hs);
    ueb_host_model_inst.packet(2, 1'b1);
    rd_chk(12'h004, 32'h9, 32'h9);
    setup_ep(32'h1);
    ueb_host_model_inst.token(2, 1'b0, hs);
    rd_chk(12'h004, 32'h20, 32'h20);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_stall();
    t_setup();
    t_out();
    t_in();
    t_iso();
    tally_and_finish();
  end
  // a hang counts against the run
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
endmodule
